/* core/pscu_pkg.sv */
package pscu_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CMP_W  = 12;
    localparam int unsigned FLG_W  = 4;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_SYNC_OUT = 8'h00;
    localparam logic [7:0] OFS_UNIT_CFG = 8'h04;
    localparam logic [7:0] OFS_CMP_BASE = 8'h10;
    localparam logic [7:0] OFS_CMP_LAST = 8'h2C;
    localparam logic [7:0] OFS_CAPTURE  = 8'h30;
    localparam logic [7:0] OFS_FLAGS    = 8'h34;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h38;
    localparam logic [7:0] OFS_STATUS   = 8'h3C;

    // ==========================================================
    // sync_output_config fields
    localparam int unsigned SOC_SEL_HI_A = 7;
    localparam int unsigned SOC_SEL_HI_B = 6;
    localparam int unsigned SOC_ADC_LSB  = 4;
    localparam int unsigned SOC_OUT_A_EN = 0;
    localparam int unsigned SOC_OUT_B_EN = 2;
    localparam logic [7:0]  SOC_MASK     = 8'hF5;
    localparam logic [7:0]  SOC_RESET    = 8'h00;

    // ==========================================================
    // unit_config_reg fields
    localparam int unsigned CFG_RUN      = 0;
    localparam int unsigned CFG_CLK_SRC  = 1;
    localparam int unsigned CFG_DIV_LSB  = 2;
    localparam int unsigned CFG_RMOD_LSB = 4;
    localparam int unsigned CFG_PART_LSB = 8;
    localparam int unsigned CFG_PART_STR = 8;
    localparam int unsigned PCF_LEVEL    = 4;
    localparam int unsigned PCF_SEL_LO   = 5;
    localparam int unsigned PCF_CAP_EN   = 6;
    localparam logic [31:0] CFG_MASK     = 32'h007F7F3F;
    localparam logic [31:0] CFG_RESET    = 32'h00000000;

    // ==========================================================
    // Compare slots, flags, counts
    localparam int unsigned CMP_SA = 0;
    localparam int unsigned CMP_RA = 1;
    localparam int unsigned CMP_SB = 2;
    localparam int unsigned CMP_RB = 3;
    localparam logic [11:0] CMP_RESET  = 12'h000;
    localparam logic [7:0]  TEMP_RESET = 8'h00;
    localparam int unsigned FLG_END_CYC = 0;
    localparam int unsigned FLG_END_ENH = 1;
    localparam int unsigned FLG_CAPTURE = 2;
    localparam int unsigned FLG_INPUT   = 3;
    localparam logic [3:0]  ENH_LAST    = 4'hE;

    localparam logic [3:0] MODE_NONE    = 4'h0;
    localparam logic [3:0] MODE_RETRIG  = 4'h8;
    localparam logic [3:0] MODE_FIXED   = 4'h9;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        RUN_ONE_RAMP  = 2'h0,
        RUN_TWO_RAMP  = 2'h1,
        RUN_FOUR_RAMP = 2'h2,
        RUN_RESERVED  = 2'h3
    } pscu_run_mode_t;

    typedef enum logic [1:0] {
        PH_DEAD0 = 2'h0,
        PH_ON0   = 2'h1,
        PH_DEAD1 = 2'h3,
        PH_ON1   = 2'h2
    } pscu_phase_t;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } pscu_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pscu_axi_rsp_t;

    // ==========================================================
    // Decoders
    function automatic logic mode_valid(input logic [3:0] mode,
                                        input logic [1:0] rmode);
        case (mode)
            4'h0, 4'h1, 4'h4, 4'h7, 4'h8, 4'h9, 4'hE: mode_valid = 1'b1;
            4'h2, 4'h3, 4'h5, 4'h6: mode_valid = (rmode != RUN_ONE_RAMP);
            default: mode_valid = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] div_mask(input logic [1:0] sel);
        case (sel)
            2'h0:    div_mask = 8'h00;
            2'h1:    div_mask = 8'h03;
            2'h2:    div_mask = 8'h1F;
            default: div_mask = 8'hFF;
        endcase
    endfunction

endpackage

/* core/pscu_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pscu_pin_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    // ==========================================================
    // Three stages; the filtered level moves only on agreement
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } pscu_sync_state_t;

    pscu_sync_state_t s_q;
    pscu_sync_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (ce) begin
            s_d.s1  = pin_in;
            s_d.s2  = s_q.s1;
            s_d.s3  = s_q.s2;
            s_d.lvl = (s_q.s2 & s_q.s3) | (s_q.lvl & (s_q.s2 ^ s_q.s3));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.lvl;

endmodule

`default_nettype wire

/* core/pscu_unit.sv */
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pscu_unit
    import pscu_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    input  wire pscu_axi_req_t axi_req,
    output pscu_axi_rsp_t      axi_rsp,
    input  wire logic          io_clk_tick,
    input  wire logic          pll_clk_tick,
    input  wire logic          shared_fault_pin,
    input  wire logic          fault_pin_a,
    input  wire logic          fault_pin_b,
    input  wire logic          comparator_out,
    input  wire logic          port_out_a,
    input  wire logic          port_out_b,
    input  wire logic          port_oe_n_a,
    input  wire logic          port_oe_n_b,
    output logic               wave_out_a,
    output logic               wave_out_b,
    output logic               wave_oe_n_a,
    output logic               wave_oe_n_b,
    output logic               adc_sync,
    output logic               unit_clock_out,
    output logic [3:0]         irq
);

    // ==========================================================
    // State
    typedef struct packed {
        logic              aw_pend;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_pend;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        pscu_axi_rsp_t     rsp;
        logic [7:0]        soc;
        logic [31:0]       cfg;
        logic [3:0][11:0]  cmp;
        logic [7:0]        temp;
        logic [11:0]       cap;
        logic [3:0]        flags;
        logic [3:0]        irq_en;
        logic [3:0]        irq;
        logic [7:0]        div;
        logic              clk_out;
        logic [11:0]       cnt;
        pscu_phase_t       phase;
        logic [3:0]        enh;
        logic [1:0]        act;
        logic [1:0]        blk;
        logic [1:0]        wave;
        logic [1:0]        pin;
        logic [1:0]        pin_oe_n;
        logic              adc_sync;
    } pscu_state_t;

    pscu_state_t s_q;
    pscu_state_t s_d;

    logic [3:0] pin_lvl;
    logic [1:0] port_o;
    logic [1:0] port_oe_n;

    assign port_o    = {port_out_b, port_out_a};
    assign port_oe_n = {port_oe_n_b, port_oe_n_a};

    // ==========================================================
    // Pin synchronisers: shared, comparator, pin A, pin B
    pscu_pin_sync #(
        .WIDTH (4)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin_in  ({fault_pin_b, fault_pin_a, comparator_out, shared_fault_pin}),
        .pin_out (pin_lvl)
    );

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic is_cmp(input logic [ADDR_W-1:0] a);
        is_cmp = (a >= OFS_CMP_BASE) && (a <= OFS_CMP_LAST) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [1:0] cmp_idx(input logic [ADDR_W-1:0] a);
        logic [2:0] t;
        t = a[5:3] - 3'h2;
        cmp_idx = t[1:0];
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wd;
        logic [3:0]        ws;
        logic [1:0]        rmode;
        logic [1:0]        mode_bad;
        logic [6:0]        pc;
        logic [3:0]        mode;
        logic [1:0]        sel;
        logic              act;
        logic              evt;
        logic              tick;
        logic              step;
        logic              reload;
        logic              run;
        logic [1:0]        wave_new;
        logic [1:0]        asel;
        logic              w_old;
        logic              w_new;
        logic              en;
        addr     = '0;
        wd       = '0;
        ws       = '0;
        rmode    = s_q.cfg[CFG_RMOD_LSB +: 2];
        mode_bad = '0;
        pc       = '0;
        mode     = '0;
        sel      = '0;
        act      = 1'b0;
        evt      = 1'b0;
        tick     = 1'b0;
        step     = 1'b0;
        reload   = 1'b0;
        run      = s_q.cfg[CFG_RUN];
        wave_new = '0;
        asel     = s_q.soc[SOC_ADC_LSB +: 2];
        w_old    = 1'b0;
        w_new    = 1'b0;
        en       = 1'b0;
        s_d      = s_q;
        for (int p = 0; p < 2; p++) begin
            mode_bad[p] = !mode_valid(s_q.cfg[CFG_PART_LSB + p*CFG_PART_STR +: 4], rmode);
        end

        if (ce) begin
            // Write channel: address and data are taken in either order
            if (axi_req.awvalid && s_q.rsp.awready) begin
                s_d.aw_pend = 1'b1;
                s_d.aw_addr = axi_req.awaddr;
            end
            if (axi_req.wvalid && s_q.rsp.wready) begin
                s_d.w_pend = 1'b1;
                s_d.w_data = axi_req.wdata;
                s_d.w_strb = axi_req.wstrb;
            end
            if (s_q.rsp.bvalid && axi_req.bready) begin
                s_d.rsp.bvalid = 1'b0;
            end
            if (s_d.aw_pend && s_d.w_pend && !s_q.rsp.bvalid) begin
                addr            = s_d.aw_addr;
                wd              = s_d.w_data;
                ws              = s_d.w_strb;
                s_d.aw_pend     = 1'b0;
                s_d.w_pend      = 1'b0;
                s_d.rsp.bvalid  = 1'b1;
                s_d.rsp.bresp   = RESP_OKAY;
                if (addr == OFS_SYNC_OUT) begin
                    if (ws[0]) begin
                        s_d.soc = wd[7:0] & SOC_MASK;
                    end
                end else if (addr == OFS_UNIT_CFG) begin
                    s_d.cfg = merge(s_q.cfg, wd, ws) & CFG_MASK;
                end else if (is_cmp(addr)) begin
                    // Low byte commits both halves at once
                    if (ws[0] && addr[2]) begin
                        s_d.cmp[cmp_idx(addr)] = {s_q.temp[3:0], wd[7:0]};
                    end else if (ws[0]) begin
                        s_d.temp = wd[7:0];
                    end
                end else if (addr == OFS_FLAGS) begin
                    if (ws[0]) begin
                        s_d.flags = s_q.flags & ~wd[FLG_W-1:0];
                    end
                end else if (addr == OFS_IRQ_EN) begin
                    if (ws[0]) begin
                        s_d.irq_en = wd[FLG_W-1:0];
                    end
                end else if (addr == OFS_CAPTURE || addr == OFS_STATUS) begin
                    s_d.rsp.bresp = RESP_OKAY;
                end else begin
                    s_d.rsp.bresp = RESP_SLVERR;
                end
            end

            // Read channel
            if (s_q.rsp.rvalid && axi_req.rready) begin
                s_d.rsp.rvalid = 1'b0;
            end
            if (axi_req.arvalid && s_q.rsp.arready) begin
                s_d.rsp.rvalid = 1'b1;
                s_d.rsp.rresp  = RESP_OKAY;
                s_d.rsp.rdata  = '0;
                if (axi_req.araddr == OFS_SYNC_OUT) begin
                    s_d.rsp.rdata[7:0] = s_q.soc;
                end else if (axi_req.araddr == OFS_UNIT_CFG) begin
                    s_d.rsp.rdata = s_q.cfg;
                end else if (is_cmp(axi_req.araddr)) begin
                    s_d.rsp.rdata = '0;
                end else if (axi_req.araddr == OFS_CAPTURE) begin
                    s_d.rsp.rdata[11:0] = s_q.cap;
                end else if (axi_req.araddr == OFS_FLAGS) begin
                    s_d.rsp.rdata[3:0] = s_q.flags;
                end else if (axi_req.araddr == OFS_IRQ_EN) begin
                    s_d.rsp.rdata[3:0] = s_q.irq_en;
                end else if (axi_req.araddr == OFS_STATUS) begin
                    s_d.rsp.rdata[17:0] = {mode_bad, s_q.wave, s_q.phase, s_q.cnt};
                end else begin
                    s_d.rsp.rresp = RESP_SLVERR;
                end
            end

            // Clock source and prescaler
            tick = s_q.cfg[CFG_CLK_SRC] ? pll_clk_tick : io_clk_tick;
            if (!run) begin
                s_d.div   = '0;
                s_d.cnt   = '0;
                s_d.phase = PH_DEAD0;
            end else if (tick) begin
                s_d.div = s_q.div + 8'h01;
                step    = (s_q.div & div_mask(s_q.cfg[CFG_DIV_LSB +: 2]))
                          == div_mask(s_q.cfg[CFG_DIV_LSB +: 2]);
            end
            s_d.clk_out = step;

            // Counter and phase sequence
            if (step) begin
                if (s_q.cnt == s_q.cmp[CMP_RB]) begin
                    reload                 = 1'b1;
                    s_d.cnt                = '0;
                    s_d.phase              = PH_DEAD0;
                    s_d.enh                = s_q.enh + 4'h1;
                    s_d.flags[FLG_END_CYC] = 1'b1;
                    if (s_q.enh == ENH_LAST) begin
                        s_d.flags[FLG_END_ENH] = 1'b1;
                    end
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                    case (s_q.phase)
                        PH_DEAD0: begin
                            if (s_q.cnt == s_q.cmp[CMP_SA]) s_d.phase = PH_ON0;
                        end
                        PH_ON0: begin
                            if (s_q.cnt == s_q.cmp[CMP_RA]) s_d.phase = PH_DEAD1;
                        end
                        PH_DEAD1: begin
                            if (s_q.cnt == s_q.cmp[CMP_SB]) s_d.phase = PH_ON1;
                        end
                        PH_ON1: begin
                            s_d.phase = PH_ON1;
                        end
                        default: begin
                            s_d.phase = PH_DEAD0;
                        end
                    endcase
                end
            end

            // Retrigger/fault parts A and B
            for (int p = 0; p < 2; p++) begin
                pc   = s_q.cfg[CFG_PART_LSB + p*CFG_PART_STR +: 7];
                mode = pc[3:0];
                sel  = {s_q.soc[SOC_SEL_HI_A - p], pc[PCF_SEL_LO]};
                act  = ~(pin_lvl[sel] ^ pc[PCF_LEVEL]);
                evt  = act && !s_q.act[p];
                s_d.act[p] = act;
                // Release before a new event so that the event wins
                if (mode == MODE_NONE || mode_bad[p]) begin
                    s_d.blk[p] = 1'b0;
                end else if (reload && (mode == MODE_FIXED || !act)) begin
                    s_d.blk[p] = 1'b0;
                end
                if (evt && run) begin
                    if (mode != MODE_NONE) begin
                        s_d.flags[FLG_INPUT] = 1'b1;
                    end
                    if (pc[PCF_CAP_EN]) begin
                        s_d.cap                = s_q.cnt;
                        s_d.flags[FLG_CAPTURE] = 1'b1;
                    end
                    if (mode_bad[p]) begin
                        s_d.flags[FLG_CAPTURE] = 1'b1;
                    end else if (mode == MODE_RETRIG) begin
                        if (s_q.phase == ((p == 0) ? PH_ON0 : PH_ON1)) begin
                            s_d.cnt                = '0;
                            s_d.phase              = PH_DEAD0;
                            s_d.flags[FLG_CAPTURE] = 1'b1;
                        end
                    end else if (mode != MODE_NONE) begin
                        s_d.blk[p] = 1'b1;
                    end
                end
            end

            // Generators, ADC sync and pins
            wave_new[0] = (s_d.phase == PH_ON0) && !s_d.blk[0];
            wave_new[1] = (s_d.phase == PH_ON1) && !s_d.blk[1];
            s_d.wave    = wave_new;
            w_old       = s_q.wave[asel[1]];
            w_new       = wave_new[asel[1]];
            s_d.adc_sync = asel[0] ? (w_old && !w_new) : (!w_old && w_new);
            for (int p = 0; p < 2; p++) begin
                en = s_q.soc[(p == 0) ? SOC_OUT_A_EN : SOC_OUT_B_EN];
                s_d.pin[p]      = en ? wave_new[p] : port_o[p];
                s_d.pin_oe_n[p] = en ? 1'b0 : port_oe_n[p];
            end
            s_d.irq = s_d.flags & s_d.irq_en;
        end

        s_d.rsp.awready = !s_d.aw_pend && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.w_pend && !s_d.rsp.bvalid;
        s_d.rsp.arready = !s_d.rsp.rvalid;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q      <= '0;
            s_q.soc  <= SOC_RESET;
            s_q.cfg  <= CFG_RESET;
            s_q.cmp  <= {4{CMP_RESET}};
            s_q.temp <= TEMP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_rsp        = s_q.rsp;
    assign wave_out_a     = s_q.pin[0];
    assign wave_out_b     = s_q.pin[1];
    assign wave_oe_n_a    = s_q.pin_oe_n[0];
    assign wave_oe_n_b    = s_q.pin_oe_n[1];
    assign adc_sync       = s_q.adc_sync;
    assign unit_clock_out = s_q.clk_out;
    assign irq            = s_q.irq;

endmodule

`default_nettype wire

/* tb/pscu_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pscu_checker
    import pscu_pkg::*;
(
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire pscu_axi_req_t axi_req,
    input wire pscu_axi_rsp_t axi_rsp,
    input wire logic          port_out_a,
    input wire logic          port_out_b,
    input wire logic          wave_out_a,
    input wire logic          wave_out_b,
    input wire logic          wave_oe_n_a,
    input wire logic          wave_oe_n_b,
    input wire logic          adc_sync,
    input wire logic [3:0]    irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Bus steps
    sequence s_wr;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    a_wr_answer: assert property (s_wr |=> axi_rsp.bvalid)
        else $error("write answer missing");
    a_rd_answer: assert property (s_rd |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read answer missing");
    a_rd_release: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
        else $error("read answer not released");
    a_cmp_read_zero: assert property (
        s_rd and axi_req.araddr inside {[OFS_CMP_BASE:OFS_CMP_LAST]} |=> axi_rsp.rdata == 32'h0)
        else $error("compare register readable");
    a_pin_a_port: assert property (wave_oe_n_a |-> wave_out_a == $past(port_out_a))
        else $error("pin A not port driven");
    a_pin_b_port: assert property (wave_oe_n_b |-> wave_out_b == $past(port_out_b))
        else $error("pin B not port driven");
    a_sync_single: assert property (adc_sync |=> !adc_sync)
        else $error("sync pulse too long");
    // Flags drop only by a write
    a_irq_sticky: assert property (
        |($past(irq) & ~irq) |->
        $past(axi_req.wvalid && axi_rsp.wready || axi_req.awvalid && axi_rsp.awready))
        else $error("interrupt dropped by itself");
endmodule
bind pscu_unit pscu_checker u_chk (.*);
`default_nettype wire

/* tb/pscu_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module pscu_far_side (
    input  wire logic       aclk,
    input  wire logic [3:0] level_cmd,
    input  wire logic       adc_sync,
    output var logic  [3:0] fault_pins,
    output var int          sync_count
);
    // Pins move after an edge
    initial sync_count = 0;
    always @(posedge aclk) begin
        fault_pins <= level_cmd;
        if (adc_sync)
            sync_count <= sync_count + 1;
    end
endmodule
`default_nettype wire

/* tb/tb_pscu_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pscu_unit
    import pscu_pkg::*;
;
    logic          aclk, aresetn, io_tick, pll_tick, wave_a, wave_b, pa, pb, adc_sync, ucko;
    pscu_axi_req_t req;
    pscu_axi_rsp_t rsp;
    logic [1:0]    tick_on, last_rr;
    logic [3:0]    pins_cmd, pins, port_v, irq;
    logic [2:0]    sel_q;
    logic [31:0]   seed;
    int            sync_count, cyc, failures, checked;
    logic [3:0]    mode_tbl [7] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'h9, 4'hE, 4'h0};

    pscu_unit i_pscu_unit (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .axi_req(req), .axi_rsp(rsp),
        .io_clk_tick(io_tick), .pll_clk_tick(pll_tick),
        .shared_fault_pin(pins[0]), .comparator_out(pins[1]),
        .fault_pin_a(pins[2]), .fault_pin_b(pins[3]),
        .port_out_a(port_v[0]), .port_out_b(port_v[1]),
        .port_oe_n_a(port_v[2]), .port_oe_n_b(port_v[3]),
        .wave_out_a(wave_a), .wave_out_b(wave_b), .wave_oe_n_a(), .wave_oe_n_b(),
        .adc_sync(adc_sync), .unit_clock_out(ucko), .irq(irq)
    );
    pscu_far_side i_pscu_far_side (.aclk(aclk), .level_cmd(pins_cmd),
        .adc_sync(adc_sync), .fault_pins(pins), .sync_count(sync_count));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] exp_pulses(input logic [1:0] s);
        exp_pulses = 32'h400 >> (s == 2'h0 ? 0 : s == 2'h1 ? 2 : s == 2'h2 ? 5 : 8);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // AW and W offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        do @(posedge aclk); while (!(rsp.awready && rsp.wready));
        req.awvalid <= 1'b0;
        req.wvalid  <= 1'b0;
        do @(posedge aclk); while (!rsp.bvalid);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        do @(posedge aclk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge aclk); while (!rsp.rvalid);
        d = rsp.rdata;
        last_rr = rsp.rresp;
    endtask
    task automatic wcmp(input int i, input int h, input logic [11:0] v);
        wr(OFS_CMP_BASE + 8'(8 * h), {28'h0, v[11:8]});
        wr(OFS_CMP_BASE + 8'(8 * i) + 8'h04, {24'h0, v[7:0]});
    endtask
    task automatic pulse(input logic [3:0] p);
        pins_cmd <= p;
        repeat (12) @(posedge aclk);
        pins_cmd <= 4'h0;
        repeat (12) @(posedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        port_v   <= 4'($random(seed));
        io_tick  <= tick_on[0] | seed[7];
        pll_tick <= tick_on[1] | seed[9];
        pa       <= wave_a;
        pb       <= wave_b;
        cyc      <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            final_report();
        end
        if (adc_sync && sel_q[2])
            chk("sync edge", {30'h0, sel_q[0] ? 2'b01 : 2'b10},
                {30'h0, sel_q[1] ? {wave_b, pb} : {wave_a, pa}});
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] d, c1;
        logic [11:0] v [4];
        int          t0;
        seed = 32'h090dd13b;
        aresetn = 1'b0;
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        {io_tick, pll_tick, pa, pb, tick_on, sel_q, pins_cmd, port_v} = '0;
        {cyc, failures, checked} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 16; k++) begin
            rd(8'(4 * k), d);
            chk("reset view", 32'h0, d);
        end
        rd(8'h40, d);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, last_rr});
        wr(OFS_SYNC_OUT, 32'hFF);
        rd(OFS_SYNC_OUT, d);
        chk("sync cfg", {24'h0, SOC_MASK}, d);
        for (int k = 0; k < 8; k++) begin
            tick_on <= k[2] ? 2'b10 : 2'b01;
            wr(OFS_UNIT_CFG, {28'h0, 2'(k), k[2], 1'b1});
            repeat (300) @(posedge aclk);
            d = 0;
            repeat (1024) begin
                @(posedge aclk);
                d += ucko;
            end
            chk("tick count", exp_pulses(2'(k)), d);
        end
        // Rising compares, every phase visited
        for (int k = 0; k < 4; k++) begin
            v[k] = (k == 0 ? 12'h004 : v[k - 1] + 12'h002) + 12'($random(seed) & 7);
            wcmp(k, (k + 1) % 4, v[k]);
        end
        wr(OFS_UNIT_CFG, 32'h3);
        for (int s = 0; s < 4; s++) begin
            sel_q <= 3'h0;
            wr(OFS_SYNC_OUT, {26'h0, 2'(s), 4'h5});
            repeat (64) @(posedge aclk);
            sel_q <= {1'b1, 2'(s)};
            t0 = sync_count;
            repeat (4 * (v[3] + 1)) @(posedge aclk);
            chk("sync count", 32'h4, 32'(sync_count - t0));
        end
        sel_q <= 3'h0;
        wr(OFS_IRQ_EN, 32'h4);
        for (int i = 0; i < 21; i++) begin
            wr(OFS_SYNC_OUT, {24'h0, i[1], 7'h05});
            wr(OFS_UNIT_CFG, {17'h0, 1'b1, i[0], 1'b1, mode_tbl[i % 7], 2'h0, 2'(i % 3), 4'h3});
            wr(OFS_FLAGS, 32'hF);
            pulse(~(4'h1 << i[1:0]));
            rd(OFS_FLAGS, d);
            chk("stray event", 32'h0, d & 32'hC);
            pulse(4'h1 << i[1:0]);
            rd(OFS_FLAGS, d);
            chk("event flags", {28'h0, mode_tbl[i % 7] != 4'h0, 3'h4}, d & 32'hC);
            chk("capture irq", 32'h1, {31'h0, irq[2]});
        end
        wr(OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge aclk);
        chk("masked irq", 32'h0, {31'h0, irq[2]});
        wr(OFS_UNIT_CFG, 32'h00005403);
        pins_cmd <= 4'h1;
        t0 = cyc;
        repeat (12) @(posedge aclk);
        pins_cmd <= 4'h0;
        rd(OFS_CAPTURE, c1);
        while (cyc != t0 + 40) @(posedge aclk);
        pins_cmd <= 4'h1;
        repeat (12) @(posedge aclk);
        rd(OFS_CAPTURE, d);
        chk("capture", (c1 + 40) % (v[3] + 1), d);
        final_report();
    end
endmodule
`default_nettype wire
